/* tb.sv */
// Self-checking bench for the scratch, low-power divisor and shadow block.
// Assumes the block and the far-side model share one 25 MHz clock.
`timescale 1ns/1ps

module tb;
    logic REF_CLK, RST, WR, RD, DIVISOR_LATCH_ACCESS, UART_BUSY, FIFO_ENABLE;
    logic NINE_BIT_ENABLE, OVERRUN_CLEAR, RX_CHAR_VALID, TX_READY, stall, slow;
    logic DATA_READY_FLAG, OVERRUN_ERROR, TX_VALID, TRANSMIT_HOLDING_EMPTY;
    logic LP_BAUD_TICK, LP_DETECT_ENABLE, lp_detect2, thr_empty2;
    logic [7:0] ADDR;
    logic [31:0] WDATA, RDATA, RDATA2, last2;
    logic [8:0] RX_CHAR, TX_CHAR;
    int error_cnt, checks, n, i;

    uart_shadow_regs uart_shadow_regs_i (.REF_CLK(REF_CLK), .RST(RST),
        .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
        .DIVISOR_LATCH_ACCESS(DIVISOR_LATCH_ACCESS), .UART_BUSY(UART_BUSY),
        .FIFO_ENABLE(FIFO_ENABLE), .NINE_BIT_ENABLE(NINE_BIT_ENABLE),
        .RX_CHAR_VALID(RX_CHAR_VALID), .RX_CHAR(RX_CHAR),
        .OVERRUN_CLEAR(OVERRUN_CLEAR), .DATA_READY_FLAG(DATA_READY_FLAG),
        .OVERRUN_ERROR(OVERRUN_ERROR), .TX_VALID(TX_VALID),
        .TX_READY(TX_READY), .TX_CHAR(TX_CHAR),
        .TRANSMIT_HOLDING_EMPTY(TRANSMIT_HOLDING_EMPTY),
        .LP_BAUD_TICK(LP_BAUD_TICK), .LP_DETECT_ENABLE(LP_DETECT_ENABLE));

    // Same bus, built without the divisor and shadow options
    uart_shadow_regs #(.LP_RX_PRESENT(1'b0), .SHADOW_PRESENT(1'b0))
        uart_shadow_regs_i2 (.REF_CLK(REF_CLK), .RST(RST), .ADDR(ADDR),
        .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA2),
        .DIVISOR_LATCH_ACCESS(DIVISOR_LATCH_ACCESS), .UART_BUSY(UART_BUSY),
        .FIFO_ENABLE(FIFO_ENABLE), .NINE_BIT_ENABLE(NINE_BIT_ENABLE),
        .RX_CHAR_VALID(RX_CHAR_VALID), .RX_CHAR(RX_CHAR),
        .OVERRUN_CLEAR(OVERRUN_CLEAR), .DATA_READY_FLAG(), .OVERRUN_ERROR(),
        .TX_VALID(), .TX_READY(TX_READY), .TX_CHAR(),
        .TRANSMIT_HOLDING_EMPTY(thr_empty2), .LP_BAUD_TICK(),
        .LP_DETECT_ENABLE(lp_detect2));

    uart_peer_model uart_peer_model_i (.clk(REF_CLK), .rst(RST),
        .stall(stall), .slow(slow), .tx_valid(TX_VALID), .tx_char(TX_CHAR),
        .tx_ready(TX_READY), .rx_valid(RX_CHAR_VALID), .rx_char(RX_CHAR));

    initial begin
        REF_CLK = 1'b0;
        forever #20 REF_CLK = ~REF_CLK;
    end

    // ======================================================================
    // Bus tasks and checking
    task summarize();
        if (error_cnt == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    task check(input string nm, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d);
        WR <= 1'b1;
        ADDR <= a;
        WDATA <= d;
        @(posedge REF_CLK);
        WR <= 1'b0;
        #1;
    endtask

    task rd(input logic [7:0] a, input logic [31:0] e);
        RD <= 1'b1;
        ADDR <= a;
        @(posedge REF_CLK);
        RD <= 1'b0;
        #1;
        last2 = RDATA2;
        check("rdata", RDATA, e);
    endtask

    // Gap between the second and third tick seen
    task tick_gap(output int g);
        int k, t0, c;
        g = -1;
        c = 0;
        t0 = 0;
        for (k = 0; k < 15000 && g < 0; k++) begin
            @(posedge REF_CLK);
            #1;
            if (LP_BAUD_TICK === 1'b1) begin
                c++;
                if (c == 3) g = k - t0;
                t0 = k;
            end
        end
        if (g < 0) begin
            error_cnt++;
            summarize();
        end
    endtask

    task wait_empty();
        int k;
        for (k = 0; k < 300 && TRANSMIT_HOLDING_EMPTY !== 1'b1; k++) begin
            @(posedge REF_CLK);
            #1;
        end
        if (TRANSMIT_HOLDING_EMPTY !== 1'b1) begin
            error_cnt++;
            summarize();
        end
    endtask

    // ======================================================================
    // Main sequence
    initial begin
        {WR, RD, DIVISOR_LATCH_ACCESS, UART_BUSY, OVERRUN_CLEAR} = 5'h00;
        {FIFO_ENABLE, NINE_BIT_ENABLE, stall, slow, RST} = 5'h15;
        ADDR = 8'h00;
        WDATA = 32'h0;
        error_cnt = 0;
        checks = 0;
        repeat (3) @(posedge REF_CLK);
        RST <= 1'b0;
        #1;
        check("thr_empty", TRANSMIT_HOLDING_EMPTY, 1'b1);
        check("lp_detect", LP_DETECT_ENABLE, 1'b0);
        rd(8'h1C, 32'h0);
        wr(8'h1C, 32'hFFFF_FFA5);
        rd(8'h1C, 32'h0000_00A5);
        wr(8'h28, 32'h0000_0033);
        rd(8'h28, 32'h0);
        wr(8'h20, 32'h0000_0044);
        @(posedge REF_CLK);
        DIVISOR_LATCH_ACCESS <= 1'b1;
        rd(8'h20, 32'h0);
        wr(8'h20, 32'h0000_000E);
        wr(8'h24, 32'h0000_0000);
        @(posedge REF_CLK);
        UART_BUSY <= 1'b1;
        wr(8'h20, 32'h0000_0055);
        rd(8'h20, 32'h0);
        @(posedge REF_CLK);
        UART_BUSY <= 1'b0;
        rd(8'h20, 32'h0000_000E);
        check("lp_absent", last2, 32'h0);
        repeat (8) @(posedge REF_CLK);
        check("lp_detect", LP_DETECT_ENABLE, 1'b1);
        check("lp_detect_absent", lp_detect2, 1'b0);
        tick_gap(n);
        check("lp_gap", n, 16 * 14);
        wr(8'h24, 32'h0000_0001);
        rd(8'h24, 32'h0000_0001);
        tick_gap(n);
        check("lp_gap", n, 16 * 270);
        wr(8'h20, 32'h0);
        wr(8'h24, 32'h0);
        n = 0;
        repeat (100) begin
            @(posedge REF_CLK);
            #1;
            if (LP_BAUD_TICK === 1'b1) n++;
        end
        check("lp_off", n, 0);
        check("lp_detect", LP_DETECT_ENABLE, 1'b0);
        uart_peer_model_i.send(9'h055);
        rd(8'h30, 32'h0);
        check("ready", DATA_READY_FLAG, 1'b1);
        @(posedge REF_CLK);
        DIVISOR_LATCH_ACCESS <= 1'b0;
        rd(8'h30, 32'h0000_0055);
        check("shadow_absent", last2, 32'h0);
        check("ready", DATA_READY_FLAG, 1'b0);
        uart_peer_model_i.send(9'h1C3);
        rd(8'h6C, 32'h0000_00C3);
        for (i = 0; i < 17; i++) uart_peer_model_i.send(9'h010 + 9'(i));
        check("overrun", OVERRUN_ERROR, 1'b1);
        for (i = 0; i < 16; i++) rd(8'h30 + 8'(4 * i), 32'h10 + i);
        check("ready", DATA_READY_FLAG, 1'b0);
        @(posedge REF_CLK);
        OVERRUN_CLEAR <= 1'b1;
        @(posedge REF_CLK);
        OVERRUN_CLEAR <= 1'b0;
        FIFO_ENABLE <= 1'b0;
        repeat (2) @(posedge REF_CLK);
        #1;
        check("overrun", OVERRUN_ERROR, 1'b0);
        uart_peer_model_i.send(9'h061);
        uart_peer_model_i.send(9'h062);
        check("overrun", OVERRUN_ERROR, 1'b1);
        rd(8'h34, 32'h0000_0062);
        check("ready", DATA_READY_FLAG, 1'b0);
        @(posedge REF_CLK);
        {FIFO_ENABLE, NINE_BIT_ENABLE, DIVISOR_LATCH_ACCESS} <= 3'h7;
        repeat (2) @(posedge REF_CLK);
        wr(8'h30, 32'h0000_00EE);
        check("tx_valid", TX_VALID, 1'b0);
        @(posedge REF_CLK);
        DIVISOR_LATCH_ACCESS <= 1'b0;
        #1;
        check("thr_empty", TRANSMIT_HOLDING_EMPTY, 1'b1);
        for (i = 0; i < 17; i++) wr(8'h30 + 8'(4 * (i % 16)), 32'h120 + i);
        check("thr_empty", TRANSMIT_HOLDING_EMPTY, 1'b0);
        check("thr_empty_absent", thr_empty2, 1'b1);
        check("ready", DATA_READY_FLAG, 1'b0);
        @(posedge REF_CLK);
        stall <= 1'b0;
        slow <= 1'b1;
        wait_empty();
        check("tx_count", uart_peer_model_i.got.size(), 16);
        for (i = 0; i < 16; i++) check("tx_char", uart_peer_model_i.got[i], 32'h20 + i);
        uart_peer_model_i.got.delete();
        @(posedge REF_CLK);
        FIFO_ENABLE <= 1'b0;
        stall <= 1'b1;
        repeat (2) @(posedge REF_CLK);
        wr(8'h38, 32'h0000_0071);
        check("thr_empty", TRANSMIT_HOLDING_EMPTY, 1'b0);
        wr(8'h3C, 32'h0000_0072);
        @(posedge REF_CLK);
        stall <= 1'b0;
        wait_empty();
        check("tx_count", uart_peer_model_i.got.size(), 1);
        check("tx_char", uart_peer_model_i.got[0], 32'h72);
        summarize();
    end
endmodule

/* uart_peer_model.sv */
// Far-side serial engine model: feeds received chars, drains transmit chars.
// Assumes it shares the register block's clock and synchronous reset.
`timescale 1ns/1ps

module uart_peer_model (
    input wire logic clk, // Shared clock
    input wire logic rst, // Synchronous reset, active high
    input wire logic stall, // Holds the transmitter off
    input wire logic slow, // Takes only every other char slot
    input wire logic tx_valid, // Char waiting at the block
    input wire logic [8:0] tx_char, // Char offered by the block
    output logic tx_ready, // Char taken this cycle
    output logic rx_valid, // Received char strobe
    output logic [8:0] rx_char // Received char
);
    logic [8:0] got[$];

    initial begin
        tx_ready = 1'b0;
        rx_valid = 1'b0;
        rx_char = 9'h000;
    end

    // ======================================================================
    // Transmit drain
    always @(posedge clk) begin
        tx_ready <= !rst && !stall && (!slow || !tx_ready);
    end

    // Handshake is sampled mid-cycle, where it is settled before the pop
    always @(negedge clk) begin
        if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
            got.push_back(tx_char);
        end
    end

    // ======================================================================
    // Receive feed, one char strobe per call
    task automatic send(input logic [8:0] c);
        @(posedge clk);
        rx_valid <= 1'b1;
        rx_char <= c;
        @(posedge clk);
        rx_valid <= 1'b0;
        rx_char <= ~c; // Released line does not keep the old char
        #1;
    endtask
endmodule

/* uart_shadow_consts.svh */
// Constants for the scratch, low-power divisor and shadow register block.
// Assumes byte addresses on an 8-bit register address bus.
`ifndef UART_SHADOW_CONSTS_SVH
`define UART_SHADOW_CONSTS_SVH

// ==========================================================================
// Register offsets (byte addresses)
`define OFS_TEMP_STORAGE 8'h1C
`define OFS_LP_DIV_LOW 8'h20
`define OFS_LP_DIV_HIGH 8'h24
`define OFS_SHADOW_FIRST 8'h30
`define OFS_SHADOW_LAST 8'h6C

// ==========================================================================
// Reset values
`define RST_TEMP_STORAGE 8'h00
`define RST_LP_DIV_BYTE 8'h00
`define RST_READ_DATA 32'h0000_0000

// ==========================================================================
// Field positions and timing counts
`define NINTH_BIT_POS 8
`define LP_PRESCALE_LAST 4'hF
`define LP_PRESCALE 16
`define FIFO_DEPTH_DEFAULT 16

`endif

/* uart_shadow_pkg.sv */
// Types shared by the scratch, low-power divisor and shadow register block.
// Assumes nothing of its surroundings.
package uart_shadow_pkg;

    // ======================================================================
    // Register region selected by the current address
    typedef enum logic [2:0] {
        SEL_NONE = 3'h0,
        SEL_SCRATCH = 3'h1,
        SEL_LP_LOW = 3'h3,
        SEL_LP_HIGH = 3'h2,
        SEL_SHADOW = 3'h6
    } reg_sel_e;

    // One character, with room for the ninth data bit
    typedef logic [8:0] char_t;

endpackage

/* uart_shadow_regs.sv */
// Scratch register, low-power divisor and shadow receive/transmit window.
// Assumes the line control, busy and FIFO enable inputs come from UART
// logic on REF_CLK, and that the serial engines use the char handshakes.
//
// Overview of operation
// - Eight-bit read/write scratch byte, reset zero, affects nothing else.
// - Unused upper bits of these registers read as zero.
// - Divisor bytes exist only with the low-power option; else read zero.
// - Divisor bytes open only with latch access set and, non-legacy, idle.
// - Low and high byte form one 16-bit divisor, each byte accessible.
// - Low-power baud tick rate is clock divided by sixteen times divisor.
// - Zero divisor stops the baud tick and all pulse detection.
// - Shadow window exists only with the shadow option; else reads zero.
// - Shadow window opens only while latch access is clear.
// - Shadow read acts as a receive buffer read, returning the char.
// - Without FIFOs a new char overwrites the unread one and flags overrun.
// - With FIFOs, read gives head; full FIFO drops new char, flags overrun.
// - Receive data is eight bits, nine with the nine-bit option.
// - Shadow write acts as a transmit holding write.
// - Without FIFOs a write clears empty; a second write overwrites.
// - With FIFOs writes fill to depth; writes while full are dropped.
// - Ninth transmit bit used only when the extended nine-bit bit is set.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "uart_shadow_consts.svh"

module uart_shadow_regs #(
    parameter bit LP_RX_PRESENT = 1'b1,
    parameter bit SHADOW_PRESENT = 1'b1,
    parameter bit NINE_BIT_PRESENT = 1'b0,
    parameter bit LEGACY_COMPAT = 1'b0,
    parameter bit FIFO_PRESENT = 1'b1,
    parameter int FIFO_DEPTH = `FIFO_DEPTH_DEFAULT
) (
    input wire logic REF_CLK, // Register and serial clock
    input wire logic RST, // Synchronous reset, active high
    input wire logic [7:0] ADDR, // Register byte address
    input wire logic [31:0] WDATA, // Register write data
    input wire logic WR, // Write strobe
    input wire logic RD, // Read strobe
    output logic [31:0] RDATA, // Read data, cycle after RD
    input wire logic DIVISOR_LATCH_ACCESS, // Line control latch access
    input wire logic UART_BUSY, // Serial transfer in progress
    input wire logic FIFO_ENABLE, // FIFO control enable bit
    input wire logic NINE_BIT_ENABLE, // Extended line control nine-bit
    input wire logic RX_CHAR_VALID, // Received char strobe
    input wire logic [8:0] RX_CHAR, // Received char
    input wire logic OVERRUN_CLEAR, // Clears the overrun flag
    output logic DATA_READY_FLAG, // Receive data present
    output logic OVERRUN_ERROR, // Sticky overrun flag
    output logic TX_VALID, // Transmit char waiting
    input wire logic TX_READY, // Transmitter takes the char
    output logic [8:0] TX_CHAR, // Char to transmit
    output logic TRANSMIT_HOLDING_EMPTY, // Nothing left to send
    output logic LP_BAUD_TICK, // Low-power baud pulse
    output logic LP_DETECT_ENABLE // Infrared pulse detection on
);

    // ======================================================================
    // Configuration check
    localparam int PW = $clog2(FIFO_DEPTH);
    localparam int CW = PW + 1;

    if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad
        $error("FIFO_DEPTH must be a power of two of at least two");
    end

    // ======================================================================
    // Address decode
    uart_shadow_pkg::reg_sel_e sel;
    logic shadow_hit;
    logic lp_open;
    logic shadow_open;
    logic fifo_on;

    assign shadow_hit = (ADDR >= `OFS_SHADOW_FIRST) &&
        (ADDR <= `OFS_SHADOW_LAST) && (ADDR[1:0] == 2'h0);
    assign sel = (ADDR == `OFS_TEMP_STORAGE) ? uart_shadow_pkg::SEL_SCRATCH :
        (ADDR == `OFS_LP_DIV_LOW) ? uart_shadow_pkg::SEL_LP_LOW :
        (ADDR == `OFS_LP_DIV_HIGH) ? uart_shadow_pkg::SEL_LP_HIGH :
        shadow_hit ? uart_shadow_pkg::SEL_SHADOW : uart_shadow_pkg::SEL_NONE;
    assign lp_open = LP_RX_PRESENT && DIVISOR_LATCH_ACCESS &&
        (LEGACY_COMPAT || !UART_BUSY);
    assign shadow_open = SHADOW_PRESENT && !DIVISOR_LATCH_ACCESS;
    assign fifo_on = FIFO_PRESENT && FIFO_ENABLE;

    // ======================================================================
    // Scratch and divisor registers
    logic [7:0] temp_q;
    logic [7:0] lp_low_q;
    logic [7:0] lp_high_q;
    logic wr_temp;
    logic wr_lp_low;
    logic wr_lp_high;
    logic [15:0] lp_div;

    assign wr_temp = WR && (sel == uart_shadow_pkg::SEL_SCRATCH);
    assign wr_lp_low = WR && (sel == uart_shadow_pkg::SEL_LP_LOW) && lp_open;
    assign wr_lp_high = WR && (sel == uart_shadow_pkg::SEL_LP_HIGH) && lp_open;
    assign lp_div = {lp_high_q, lp_low_q};

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            temp_q <= `RST_TEMP_STORAGE;
            lp_low_q <= `RST_LP_DIV_BYTE;
            lp_high_q <= `RST_LP_DIV_BYTE;
        end else begin
            if (wr_temp) begin
                temp_q <= WDATA[7:0];
            end
            if (wr_lp_low) begin
                lp_low_q <= WDATA[7:0];
            end
            if (wr_lp_high) begin
                lp_high_q <= WDATA[7:0];
            end
        end
    end

    // ======================================================================
    // Low-power baud generator
    logic [3:0] pre_q;
    logic [15:0] div_cnt_q;
    logic lp_zero;
    logic pre_wrap;
    logic lp_wrap;

    assign lp_zero = (lp_div == 16'h0000);
    assign pre_wrap = (pre_q == `LP_PRESCALE_LAST);
    assign lp_wrap = !lp_zero && pre_wrap && (div_cnt_q >= lp_div - 16'h0001);
    assign LP_DETECT_ENABLE = !lp_zero;

    always_ff @(posedge REF_CLK) begin
        if (RST || lp_zero) begin
            pre_q <= 4'h0;
            div_cnt_q <= 16'h0000;
            LP_BAUD_TICK <= 1'b0;
        end else begin
            pre_q <= pre_q + 4'h1;
            if (lp_wrap) begin
                div_cnt_q <= 16'h0000;
            end else if (pre_wrap) begin
                div_cnt_q <= div_cnt_q + 16'h0001;
            end
            LP_BAUD_TICK <= lp_wrap;
        end
    end

    // ======================================================================
    // Receive path
    uart_shadow_pkg::char_t rx_mem [FIFO_DEPTH];
    logic [PW-1:0] rx_wr_q;
    logic [PW-1:0] rx_rd_q;
    logic [CW-1:0] rx_cnt_q;
    logic [CW-1:0] rx_cnt_d;
    logic fifo_on_q;
    logic flush;
    logic rx_pop;
    logic rx_full;
    logic rx_lost;
    logic rx_push;
    logic rx_overwrite;
    logic overrun_q;
    uart_shadow_pkg::char_t rx_in;
    uart_shadow_pkg::char_t rx_head;

    assign flush = (fifo_on != fifo_on_q);
    assign rx_pop = RD && (sel == uart_shadow_pkg::SEL_SHADOW) &&
        shadow_open && (rx_cnt_q != '0);
    assign rx_full = fifo_on ? (rx_cnt_q == CW'(FIFO_DEPTH)) :
        (rx_cnt_q != '0);
    assign rx_lost = RX_CHAR_VALID && rx_full && !rx_pop;
    assign rx_push = RX_CHAR_VALID && !rx_lost;
    assign rx_overwrite = rx_lost && !fifo_on;
    assign rx_in = {NINE_BIT_PRESENT && RX_CHAR[`NINTH_BIT_POS],
        RX_CHAR[7:0]};
    assign rx_head = rx_mem[rx_rd_q];
    assign rx_cnt_d = flush ? '0 :
        rx_cnt_q + CW'(rx_push) - CW'(rx_pop);
    assign DATA_READY_FLAG = (rx_cnt_q != '0);
    assign OVERRUN_ERROR = overrun_q;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            for (int i = 0; i < FIFO_DEPTH; i++) begin
                rx_mem[i] <= 9'h000;
            end
        end else if (rx_push) begin
            rx_mem[rx_wr_q] <= rx_in;
        end else if (rx_overwrite) begin
            rx_mem[rx_rd_q] <= rx_in;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            rx_wr_q <= '0;
            rx_rd_q <= '0;
            rx_cnt_q <= '0;
            fifo_on_q <= 1'b0;
            overrun_q <= 1'b0;
        end else begin
            fifo_on_q <= fifo_on;
            rx_cnt_q <= rx_cnt_d;
            if (flush) begin
                rx_wr_q <= '0;
                rx_rd_q <= '0;
            end else begin
                if (rx_push) begin
                    rx_wr_q <= rx_wr_q + PW'(1);
                end
                if (rx_pop) begin
                    rx_rd_q <= rx_rd_q + PW'(1);
                end
            end
            if (rx_lost) begin
                overrun_q <= 1'b1;
            end else if (OVERRUN_CLEAR) begin
                overrun_q <= 1'b0;
            end
        end
    end

    // ======================================================================
    // Transmit path
    uart_shadow_pkg::char_t tx_mem [FIFO_DEPTH];
    logic [PW-1:0] tx_wr_q;
    logic [PW-1:0] tx_rd_q;
    logic [CW-1:0] tx_cnt_q;
    logic [CW-1:0] tx_cnt_d;
    logic tx_wr;
    logic tx_pop;
    logic tx_full;
    logic tx_push;
    logic tx_overwrite;
    uart_shadow_pkg::char_t tx_in;

    assign tx_wr = WR && (sel == uart_shadow_pkg::SEL_SHADOW) && shadow_open;
    assign tx_pop = TX_VALID && TX_READY;
    assign tx_full = fifo_on ? (tx_cnt_q == CW'(FIFO_DEPTH)) :
        (tx_cnt_q != '0);
    assign tx_push = tx_wr && !(tx_full && !tx_pop);
    assign tx_overwrite = tx_wr && !fifo_on && tx_full && !tx_pop;
    assign tx_in = {NINE_BIT_PRESENT && NINE_BIT_ENABLE &&
        WDATA[`NINTH_BIT_POS], WDATA[7:0]};
    assign tx_cnt_d = flush ? '0 :
        tx_cnt_q + CW'(tx_push) - CW'(tx_pop);
    assign TX_VALID = (tx_cnt_q != '0);
    assign TX_CHAR = tx_mem[tx_rd_q];
    assign TRANSMIT_HOLDING_EMPTY = (tx_cnt_q == '0);

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            for (int i = 0; i < FIFO_DEPTH; i++) begin
                tx_mem[i] <= 9'h000;
            end
        end else if (tx_push) begin
            tx_mem[tx_wr_q] <= tx_in;
        end else if (tx_overwrite) begin
            tx_mem[tx_rd_q] <= tx_in;
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            tx_wr_q <= '0;
            tx_rd_q <= '0;
            tx_cnt_q <= '0;
        end else begin
            tx_cnt_q <= tx_cnt_d;
            if (flush) begin
                tx_wr_q <= '0;
                tx_rd_q <= '0;
            end else begin
                if (tx_push) begin
                    tx_wr_q <= tx_wr_q + PW'(1);
                end
                if (tx_pop) begin
                    tx_rd_q <= tx_rd_q + PW'(1);
                end
            end
        end
    end

    // ======================================================================
    // Read data
    logic [31:0] rd_mux;

    assign rd_mux =
        (sel == uart_shadow_pkg::SEL_SCRATCH) ? {24'h000000, temp_q} :
        (sel == uart_shadow_pkg::SEL_LP_LOW && lp_open) ?
            {24'h000000, lp_low_q} :
        (sel == uart_shadow_pkg::SEL_LP_HIGH && lp_open) ?
            {24'h000000, lp_high_q} :
        (sel == uart_shadow_pkg::SEL_SHADOW && shadow_open) ?
            {23'h000000, rx_head} : `RST_READ_DATA;

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            RDATA <= `RST_READ_DATA;
        end else begin
            RDATA <= RD ? rd_mux : `RST_READ_DATA;
        end
    end

    // ======================================================================
    // Checks
    logic [15:0] lp_div_prev_q;
    logic [20:0] gap_q;
    logic tick_seen_q;
    logic div_chg;

    assign div_chg = (lp_div != lp_div_prev_q);

    always_ff @(posedge REF_CLK) begin
        if (RST) begin
            lp_div_prev_q <= 16'h0000;
            gap_q <= 21'h000001;
            tick_seen_q <= 1'b0;
        end else begin
            lp_div_prev_q <= lp_div;
            gap_q <= LP_BAUD_TICK ? 21'h000001 : gap_q + 21'h000001;
            tick_seen_q <= div_chg ? 1'b0 : (tick_seen_q | LP_BAUD_TICK);
        end
    end

    a_scratch_readback:
    assert property (@(posedge REF_CLK) disable iff (RST)
        (wr_temp ##1 (RD && sel == uart_shadow_pkg::SEL_SCRATCH)) |=>
        (RDATA == {24'h000000, $past(WDATA[7:0], 2)}))
    else $error("scratch byte did not read back");
    a_upper_zero:
    assert property (@(posedge REF_CLK) disable iff (RST)
        RDATA[31:9] == 23'h000000)
    else $error("upper read bits not zero");
    a_lp_closed:
    assert property (@(posedge REF_CLK) disable iff (RST)
        (WR && sel == uart_shadow_pkg::SEL_LP_LOW && !lp_open) |=>
        (lp_low_q == $past(lp_low_q)))
    else $error("divisor low byte written while closed");
    a_lp_absent:
    assert property (@(posedge REF_CLK) disable iff (RST)
        (RD && sel == uart_shadow_pkg::SEL_LP_HIGH && !lp_open) |=>
        (RDATA == 32'h0000_0000))
    else $error("closed divisor byte read nonzero");
    a_lp_period:
    assert property (@(posedge REF_CLK) disable iff (RST)
        (LP_BAUD_TICK && tick_seen_q && !div_chg) |->
        (gap_q == 21'(lp_div) * 21'(`LP_PRESCALE)))
    else $error("low-power tick period wrong");
    a_lp_zero_stop:
    assert property (@(posedge REF_CLK) disable iff (RST)
        (lp_zero && $past(lp_zero)) |-> (!LP_BAUD_TICK && !LP_DETECT_ENABLE))
    else $error("tick while divisor zero");
    a_rx_overwrite:
    assert property (@(posedge REF_CLK) disable iff (RST)
        (rx_overwrite && !flush) |=>
        (OVERRUN_ERROR && DATA_READY_FLAG && rx_head == $past(rx_in)))
    else $error("non-FIFO overrun not handled");
    a_rx_full_keep:
    assert property (@(posedge REF_CLK) disable iff (RST)
        (rx_lost && fifo_on && !flush) |=>
        (OVERRUN_ERROR && rx_cnt_q == $past(rx_cnt_q)))
    else $error("full receive FIFO did not keep data");

    a_rx_pop:
    assert property (@(posedge REF_CLK) disable iff (RST)
        (rx_pop && !RX_CHAR_VALID && !flush) |=>
        (rx_cnt_q == $past(rx_cnt_q) - CW'(1) &&
        RDATA[8:0] == $past(rx_head)))
    else $error("shadow read did not pop receive data");

    a_thr_clear:
    assert property (@(posedge REF_CLK) disable iff (RST)
        (tx_wr && !fifo_on && !tx_pop && !flush) |=>
        (!TRANSMIT_HOLDING_EMPTY && TX_CHAR == $past(tx_in)))
    else $error("non-FIFO write not held");

    a_tx_drop:
    assert property (@(posedge REF_CLK) disable iff (RST)
        (tx_wr && fifo_on && tx_full && !tx_pop && !flush) |=>
        (tx_cnt_q == $past(tx_cnt_q)))
    else $error("write into full transmit FIFO kept");

    a_shadow_closed:
    assert property (@(posedge REF_CLK) disable iff (RST)
        (WR && shadow_hit && DIVISOR_LATCH_ACCESS && !TX_VALID && !flush) |=>
        TRANSMIT_HOLDING_EMPTY)
    else $error("shadow write taken with latch access set");

endmodule
